/* verilog/bsl_defines.vh */
// Timing constants and codes for the bit synchronizer lock sequencer
`ifndef BSL_DEFINES_VH
`define BSL_DEFINES_VH

// Chip-rate clock period in ns (clock runs at chip rate)
`define BSL_CLK_NS          10
// Repetition window, chips per bit at the low rate
`define BSL_REP_CHIPS       8'd128
// Gate widths in chips
`define BSL_WIN_WIDE        8'd8
`define BSL_WIN_NARROW      8'd2
`define BSL_ADV_CHIPS       8'd60
`define BSL_RET_CHIPS       8'd60
`define BSL_BLANK_CHIPS     8'd8
`define BSL_MP_CHIPS        8'd8
// Bit-period counts
`define BSL_LOCK_BITS       6'd10
`define BSL_EOP_BITS        6'd38
// Window positions within the repetition period
`define BSL_WIN_START       8'd60
`define BSL_RET_START       8'd68
// Slew command codes
`define BSL_SLEW_NONE       2'h0
`define BSL_SLEW_ADV        2'h1
`define BSL_SLEW_RET        2'h2
// Loop bandwidth codes
`define BSL_BW_FREE         2'h0
`define BSL_BW_ACQ          2'h1
`define BSL_BW_NARROW       2'h2
// Gain-control mode codes
`define BSL_AGC_RESET       2'h0
`define BSL_AGC_SET         2'h1
`define BSL_AGC_HOLD        2'h2
`define BSL_AGC_BLANK       2'h3

`endif

/* verilog/bsl_chip_timer.v */
// Chip position counter across one repetition window with bit-period tick
`timescale 1ns/100ps
`include "bsl_defines.vh"

module bsl_chip_timer (
    input  wire       i_clk,
    input  wire       i_arst_n,
    input  wire       i_ce,
    input  wire       i_clr,
    input  wire       i_slip,
    input  wire       i_skip,
    output wire [7:0] o_pos,
    output wire       o_bit_tick
);

    reg  [7:0] pos_ff;
    reg  [7:0] nxt_pos;

    // -----------------------------------------------------------------
    // Position update: slip holds a chip, skip jumps one extra chip
    // -----------------------------------------------------------------
    always @* begin
        if (i_clr) begin
            nxt_pos = 8'h00;
        end else if (i_slip) begin
            nxt_pos = pos_ff;
        end else if (i_skip) begin
            nxt_pos = (pos_ff >= `BSL_REP_CHIPS - 8'd2) ?
                      pos_ff + 8'd2 - `BSL_REP_CHIPS : pos_ff + 8'd2;
        end else begin
            nxt_pos = (pos_ff == `BSL_REP_CHIPS - 8'd1) ? 8'h00 : pos_ff + 8'd1;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pos_ff <= 8'h00;
        end else if (i_ce) begin
            pos_ff <= nxt_pos;
        end
    end

    assign o_pos      = pos_ff;
    assign o_bit_tick = (pos_ff == `BSL_REP_CHIPS - 8'd1) && !i_slip && !i_clr;

endmodule

/* verilog/bsl_bit_counter.v */
// Bit-period counter with clear, used for lock and preamble timeouts
`timescale 1ns/100ps
`include "bsl_defines.vh"

module bsl_bit_counter (
    input  wire       i_clk,
    input  wire       i_arst_n,
    input  wire       i_ce,
    input  wire       i_clr,
    input  wire       i_tick,
    output wire [5:0] o_count
);

    reg  [5:0] cnt_ff;

    // -----------------------------------------------------------------
    // Count bit ticks, saturating at the top
    // -----------------------------------------------------------------
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_ff <= 6'h00;
        end else if (i_ce) begin
            if (i_clr) begin
                cnt_ff <= 6'h00;
            end else if (i_tick && cnt_ff != 6'h3f) begin
                cnt_ff <= cnt_ff + 6'h01;
            end
        end
    end

    assign o_count = cnt_ff;

endmodule

/* verilog/bsl_lock_seq.v */
// Bit synchronizer acquisition, lock and preamble sequencer
`timescale 1ns/100ps
`include "bsl_defines.vh"

module bsl_lock_seq (
    input  wire       i_clk,
    input  wire       i_arst_n,
    input  wire       i_ce,
    input  wire       i_listen_permit,
    input  wire       i_preamble_done,
    input  wire       i_multi_det,
    input  wire       i_peak_win,
    input  wire       i_peak_adv,
    input  wire       i_peak_ret,
    output reg        o_sample_win,
    output reg        o_adv_gate,
    output reg        o_ret_gate,
    output reg  [1:0] o_slew,
    output reg  [1:0] o_loop_bw,
    output reg        o_in_lock,
    output reg        o_carrier_sense,
    output reg        o_sync_done,
    output reg        o_multipath_gate,
    output reg        o_blank,
    output reg  [1:0] o_cagc_mode,
    output reg  [1:0] o_nagc_mode,
    output reg        o_bit_timing
);

    // -----------------------------------------------------------------
    // States, one-hot
    // -----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ACQ  = 4'b0010;
    localparam [3:0] ST_LOCK = 4'b0100;
    localparam [3:0] ST_TRK  = 4'b1000;

    reg  [3:0] state_ff;
    reg  [3:0] nxt_state;
    reg        lock_dly_ff;
    reg        clr_bits;
    reg        in_acq;
    reg        in_locked;

    wire [7:0] pos;
    wire       bit_tick;
    wire [5:0] bit_cnt;
    wire       adv_now;
    wire       ret_now;
    wire       wide_now;
    wire       narrow_now;
    wire       mp_now;
    wire       blank_now;
    wire       hit_lock;
    wire       eop_ok;
    reg  [1:0] nxt_slew;

    // -----------------------------------------------------------------
    // Chip and bit counters
    // -----------------------------------------------------------------
    bsl_chip_timer u_chip (
        .i_clk      (i_clk),
        .i_arst_n   (i_arst_n),
        .i_ce       (i_ce),
        .i_clr      (state_ff == ST_IDLE),
        .i_slip     (o_slew == `BSL_SLEW_RET),
        .i_skip     (o_slew == `BSL_SLEW_ADV),
        .o_pos      (pos),
        .o_bit_tick (bit_tick)
    );

    bsl_bit_counter u_bits (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_clr    (clr_bits),
        .i_tick   (bit_tick),
        .o_count  (bit_cnt)
    );

    // -----------------------------------------------------------------
    // Gate decode from chip position
    // -----------------------------------------------------------------
    assign adv_now    = pos < `BSL_ADV_CHIPS;
    assign ret_now    = pos >= `BSL_RET_START &&
                        pos < `BSL_RET_START + `BSL_RET_CHIPS;
    assign wide_now   = pos >= `BSL_WIN_START &&
                        pos < `BSL_WIN_START + `BSL_WIN_WIDE;
    assign narrow_now = pos >= `BSL_WIN_START + 8'd3 &&
                        pos < `BSL_WIN_START + 8'd3 + `BSL_WIN_NARROW;
    assign mp_now     = pos >= `BSL_WIN_START &&
                        pos < `BSL_WIN_START + `BSL_MP_CHIPS;
    assign blank_now  = pos >= `BSL_WIN_START &&
                        pos < `BSL_WIN_START + `BSL_BLANK_CHIPS;

    // Lock test and preamble qualification
    assign hit_lock = bit_tick && bit_cnt == `BSL_LOCK_BITS - 6'd1;
    assign eop_ok   = i_preamble_done && lock_dly_ff;

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        clr_bits  = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                clr_bits = 1'b1;
                if (i_listen_permit) begin
                    nxt_state = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (o_slew != `BSL_SLEW_NONE) begin
                    clr_bits = 1'b1;
                end
                if (hit_lock) begin
                    clr_bits = 1'b1;
                    if (i_listen_permit) begin
                        nxt_state = ST_LOCK;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_LOCK: begin
                if (eop_ok) begin
                    nxt_state = ST_TRK;
                end else if (bit_cnt >= `BSL_EOP_BITS) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_TRK: begin
                if (!i_listen_permit) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                clr_bits  = 1'b1;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Advance/retard comparison, searching only while acquiring
    // -----------------------------------------------------------------
    always @* begin
        in_acq    = state_ff == ST_ACQ;
        in_locked = state_ff == ST_LOCK || state_ff == ST_TRK;
        nxt_slew  = `BSL_SLEW_NONE;
        // Peak before the window: skip a chip so the window moves earlier
        // Peak after the window: hold a chip so the window moves later
        if (in_acq && bit_tick) begin
            if (i_peak_adv && !i_peak_win) begin
                nxt_slew = `BSL_SLEW_ADV;
            end else if (i_peak_ret && !i_peak_win) begin
                nxt_slew = `BSL_SLEW_RET;
            end
        end
    end

    // -----------------------------------------------------------------
    // Sequencer state and delayed lock
    // -----------------------------------------------------------------
    // The delayed lock keeps a preamble flag that arrives with the lock
    // edge itself from completing the sequence too early
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff    <= ST_IDLE;
            lock_dly_ff <= 1'b0;
        end else if (i_ce) begin
            state_ff    <= nxt_state;
            lock_dly_ff <= o_in_lock;
        end
    end

    // -----------------------------------------------------------------
    // Slew pulse and bit timing
    // -----------------------------------------------------------------
    // Slew lasts one chip so the timer moves by exactly one position
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_slew       <= `BSL_SLEW_NONE;
            o_bit_timing <= 1'b0;
        end else if (i_ce) begin
            o_slew       <= nxt_slew;
            o_bit_timing <= pos < (`BSL_REP_CHIPS >> 1);                      // Half-bit square wave
        end
    end

    // -----------------------------------------------------------------
    // Sample window and search gates
    // -----------------------------------------------------------------
    // Gates follow the current state, so they lag the state by one chip
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sample_win <= 1'b0;
            o_adv_gate   <= 1'b0;
            o_ret_gate   <= 1'b0;
        end else if (i_ce) begin
            // Window narrows once locked
            o_sample_win <= in_locked ? narrow_now : (in_acq && wide_now);
            o_adv_gate   <= in_acq && adv_now;
            o_ret_gate   <= in_acq && ret_now;
        end
    end

    // -----------------------------------------------------------------
    // Lock, carrier sense and completion flags
    // -----------------------------------------------------------------
    // Taken from the next state so the flags rise with the state change
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_in_lock       <= 1'b0;
            o_carrier_sense <= 1'b0;
            o_sync_done     <= 1'b0;
        end else if (i_ce) begin
            o_in_lock       <= nxt_state == ST_LOCK || nxt_state == ST_TRK;
            o_carrier_sense <= nxt_state == ST_LOCK || nxt_state == ST_TRK;
            o_sync_done     <= nxt_state == ST_TRK;
        end
    end

    // -----------------------------------------------------------------
    // Loop bandwidth command
    // -----------------------------------------------------------------
    // Narrow bandwidth only after completion, to cut tracking jitter
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_loop_bw <= `BSL_BW_FREE;
        end else if (i_ce) begin
            if (nxt_state == ST_TRK) begin
                o_loop_bw <= `BSL_BW_NARROW;
            end else if (nxt_state == ST_IDLE) begin
                o_loop_bw <= `BSL_BW_FREE;
            end else begin
                o_loop_bw <= `BSL_BW_ACQ;
            end
        end
    end

    // -----------------------------------------------------------------
    // Multipath gate and blanking
    // -----------------------------------------------------------------
    // Gate stays open while searching so no peak is hidden from the loop
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_multipath_gate <= 1'b1;
            o_blank          <= 1'b0;
        end else if (i_ce) begin
            o_multipath_gate <= in_locked ? mp_now : 1'b1;
            // Blanking only for multi-detector slotted use
            o_blank <= i_multi_det && in_locked && blank_now;
        end
    end

    // -----------------------------------------------------------------
    // Gain control modes
    // -----------------------------------------------------------------
    // Both gain loops freeze at completion for the rest of the packet
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cagc_mode <= `BSL_AGC_RESET;
            o_nagc_mode <= `BSL_AGC_RESET;
        end else if (i_ce) begin
            if (nxt_state == ST_TRK) begin
                o_cagc_mode <= `BSL_AGC_HOLD;
                o_nagc_mode <= `BSL_AGC_HOLD;
            end else if (nxt_state == ST_IDLE) begin
                o_cagc_mode <= `BSL_AGC_RESET;
                o_nagc_mode <= `BSL_AGC_RESET;
            end else if (i_multi_det && in_locked && blank_now) begin
                o_cagc_mode <= `BSL_AGC_BLANK;
                o_nagc_mode <= `BSL_AGC_SET;
            end else begin
                o_cagc_mode <= `BSL_AGC_SET;
                o_nagc_mode <= `BSL_AGC_SET;
            end
        end
    end

endmodule

/* testbench/bsl_lock_seq_sva.sv */
// Port checker for the bit synchronizer lock sequencer
`timescale 1ns/100ps
`include "bsl_defines.vh"

module bsl_lock_seq_sva (
    input wire       i_clk,
    input wire       i_arst_n,
    input wire       i_listen_permit,
    input wire       i_preamble_done,
    input wire       i_multi_det,
    input wire       o_sample_win,
    input wire       o_adv_gate,
    input wire       o_ret_gate,
    input wire [1:0] o_slew,
    input wire [1:0] o_loop_bw,
    input wire       o_in_lock,
    input wire       o_carrier_sense,
    input wire       o_sync_done,
    input wire       o_multipath_gate,
    input wire       o_blank,
    input wire [1:0] o_cagc_mode,
    input wire [1:0] o_nagc_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    reg [13:0] wait_cyc_ff;

    // Cycles spent locked while the preamble is awaited
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            wait_cyc_ff <= 14'h0000;
        else
            wait_cyc_ff <= (o_in_lock && !o_sync_done) ? wait_cyc_ff + 14'h0001 : 14'h0000;
    end

    a_idle_gates_off: assert property (o_loop_bw == `BSL_BW_FREE
        && $past(o_loop_bw) == `BSL_BW_FREE |-> !o_sample_win && !o_adv_gate && !o_ret_gate)
        else $error("gate active while idle");
    a_wide_window: assert property ($rose(o_sample_win) && !o_in_lock && !o_sync_done
        |=> o_sample_win [*7] ##1 !o_sample_win) else $error("wide window width");
    a_narrow_window: assert property ($rose(o_sample_win) && (o_in_lock || o_sync_done)
        |=> o_sample_win ##1 !o_sample_win) else $error("narrow window width");
    a_search_off: assert property (o_in_lock && $past(o_in_lock)
        |-> !o_adv_gate && !o_ret_gate) else $error("search gates in lock");
    a_carrier_sense: assert property (o_carrier_sense == o_in_lock)
        else $error("carrier sense mismatch");
    a_lock_permit: assert property ($rose(o_in_lock) |-> $past(i_listen_permit))
        else $error("lock without permit");
    a_done_cause: assert property ($rose(o_sync_done)
        |-> $past(i_preamble_done) && $past(o_in_lock)) else $error("sync done without cause");
    a_done_modes: assert property (o_sync_done |-> o_loop_bw == `BSL_BW_NARROW
        && o_cagc_mode == `BSL_AGC_HOLD && o_nagc_mode == `BSL_AGC_HOLD) else $error("track modes");
    a_lock_timeout: assert property (wait_cyc_ff <= 14'd4868)
        else $error("preamble wait too long");
    a_blank_mode: assert property (o_blank |-> $past(i_multi_det))
        else $error("blank outside multi mode");
    a_blank_width: assert property ($rose(o_blank) |=> o_blank [*7] ##1 !o_blank)
        else $error("blank width");
    a_gate_open: assert property (!o_in_lock && !$past(o_in_lock) && !o_sync_done
        && !$past(o_sync_done) |-> o_multipath_gate) else $error("multipath gate closed");
    a_slew_pulse: assert property (o_slew != `BSL_SLEW_NONE |-> o_loop_bw == `BSL_BW_ACQ
        ##1 o_slew == `BSL_SLEW_NONE) else $error("slew pulse");
endmodule

bind bsl_lock_seq bsl_lock_seq_sva u_sva (.*);

/* testbench/bsl_host_model.sv */
// Host permit and preamble detector model facing the lock sequencer
`timescale 1ns/100ps

module bsl_host_model (
    input  wire        i_clk,
    input  wire        i_in_lock,
    input  wire        i_permit_req,
    input  wire        i_eop_en,
    input  wire        i_eop_early,
    input  wire [13:0] i_eop_delay,
    output wire        o_listen_permit,
    output reg         o_preamble_done = 1'b0
);
    reg [13:0] wait_ff  = 14'h0000;
    reg        armed_ff = 1'b0;

    // Permit is a host level that follows its request
    assign o_listen_permit = i_permit_req;

    // One end of preamble per lock, never later than 38 bits after it
    always @(posedge i_clk) begin
        o_preamble_done <= i_eop_early;
        wait_ff         <= i_in_lock ? wait_ff + 14'h0001 : 14'h0000;
        armed_ff        <= i_in_lock ? armed_ff : 1'b1;
        if (i_in_lock && armed_ff && i_eop_en
            && (wait_ff >= i_eop_delay || wait_ff >= 14'd4800)) begin
            o_preamble_done <= 1'b1;
            armed_ff        <= 1'b0;
        end
    end
endmodule

/* testbench/test_bsl_lock_seq.sv */
// Self-checking bench for the bit synchronizer lock sequencer
`timescale 1ns/100ps
`include "bsl_defines.vh"

module test_bsl_lock_seq;
    reg         i_clk = 1'b0;
    reg         i_arst_n = 1'b0;
    reg         i_ce = 1'b1;
    reg         i_multi_det = 1'b1;
    reg         i_peak_win = 1'b0;
    reg         i_peak_adv = 1'b1;
    reg         i_peak_ret = 1'b0;
    reg         permit_req = 1'b0;
    reg         eop_en = 1'b0;
    reg         eop_early = 1'b0;
    wire        i_listen_permit, i_preamble_done, o_sample_win, o_adv_gate, o_ret_gate;
    wire        o_in_lock, o_carrier_sense, o_sync_done, o_multipath_gate, o_blank, o_bit_timing;
    wire [1:0]  o_slew, o_loop_bw, o_cagc_mode, o_nagc_mode;
    wire [6:0]  mon = {o_slew, o_blank, o_sync_done, o_in_lock, o_loop_bw};
    wire [5:0]  gates = {o_bit_timing, o_blank, o_multipath_gate, o_sample_win, o_ret_gate,
                         o_adv_gate};
    integer     miscompares = 0;
    integer     check_count = 0;
    integer     waited, i, k;
    integer     cnt [0:5];

    always #5 i_clk = ~i_clk;

    bsl_lock_seq u_dut (.*);
    bsl_host_model u_host (.i_clk(i_clk), .i_in_lock(o_in_lock), .i_permit_req(permit_req),
        .i_eop_en(eop_en), .i_eop_early(eop_early), .i_eop_delay(14'd300),
        .o_listen_permit(i_listen_permit), .o_preamble_done(i_preamble_done));

    // Count and report one comparison
    task chk(input logic ok, input string msg);
        check_count = check_count + 1;
        if (ok !== 1'b1) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // Bounded wait until the masked status matches
    task wait_mon(input [6:0] mask, input [6:0] val, input integer max);
        waited = 0;
        while ((mon & mask) !== val && waited < max) begin
            @(negedge i_clk);
            waited = waited + 1;
        end
    endtask

    // High cycles of each gate over one bit period
    task measure_gates(input integer a, r, w, m, b, input string msg);
        for (i = 0; i < 6; i = i + 1) cnt[i] = 0;
        repeat (128) begin
            @(negedge i_clk);
            for (i = 0; i < 6; i = i + 1) cnt[i] = cnt[i] + gates[i];
        end
        chk(cnt[0] == a && cnt[1] == r && cnt[2] == w && cnt[3] == m && cnt[4] == b
            && cnt[5] == 64, msg);
    endtask

    task stop_test;
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #500000;
        miscompares = miscompares + 1;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end

    // Test sequence
    initial begin
        repeat (4) @(negedge i_clk);
        chk(mon === 7'h00 && o_multipath_gate === 1'b1 && o_cagc_mode === 2'h0, "reset");
        i_arst_n = 1'b1;
        repeat (300) @(negedge i_clk);
        chk(o_loop_bw === `BSL_BW_FREE && gates === 6'h28, "idle without permit");
        $display("test idle done");
        permit_req = 1'b1;
        for (k = 0; k < 2; k = k + 1) begin
            i_peak_adv = (k == 0);
            i_peak_ret = (k == 1);
            wait_mon(7'h60, k ? 7'h40 : 7'h20, 300);
            chk((mon & 7'h67) === (k ? 7'h41 : 7'h21), "slew direction");
        end
        i_peak_ret = 1'b0;
        i_peak_win = 1'b1;
        eop_early = 1'b1;
        repeat (3) @(negedge i_clk);
        eop_early = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_sync_done === 1'b0, "early preamble ignored");
        measure_gates(60, 60, 8, 128, 0, "acquisition gates");
        wait_mon(7'h04, 7'h04, 1600);
        chk(o_in_lock === 1'b1 && o_carrier_sense === 1'b1, "lock raised");
        measure_gates(0, 0, 2, 8, 8, "locked gates");
        eop_en = 1'b1;
        wait_mon(7'h08, 7'h08, 600);
        chk(o_sync_done === 1'b1 && o_loop_bw === `BSL_BW_NARROW, "sync done");
        chk(o_cagc_mode === `BSL_AGC_HOLD && o_nagc_mode === `BSL_AGC_HOLD, "hold");
        eop_en = 1'b0;
        @(negedge o_blank);
        permit_req = 1'b0;
        wait_mon(7'h0b, 7'h00, 300);
        chk((mon & 7'h0b) === 7'h00, "permit drop");
        $display("test lock and track done");
        permit_req = 1'b1;
        wait_mon(7'h04, 7'h04, 1600);
        wait_mon(7'h04, 7'h00, 5200);
        chk(waited >= 4700 && o_in_lock === 1'b0, "preamble timeout");
        $display("test timeout done");
        repeat (600) @(negedge i_clk);
        @(negedge o_sample_win);
        permit_req = 1'b0;
        wait_mon(7'h04, 7'h04, 1600);
        chk(o_in_lock === 1'b0 && o_loop_bw === `BSL_BW_FREE, "no lock without permit");
        $display("test permit loss done");
        stop_test;
    end
endmodule
